// [rtl/host_port_pkg.sv]
// shared constants, encodings and carriers of the serial host port
// assumes a single core clock; the spi link clock is the host's serial clock
package host_port_pkg;

  // ------------------------------------------------------------
  // host link straps
  // ------------------------------------------------------------
  localparam logic [2:0] STRAP_SPI3 = 3'b100;
  localparam logic [2:0] STRAP_SPI4 = 3'b101;
  localparam logic [1:0] STRAP_I2C_HI = 2'b11;

  typedef enum logic [3:0] {
    MODE_NONE = 4'b0001,
    MODE_SPI3 = 4'b0010,
    MODE_SPI4 = 4'b0100,
    MODE_I2C = 4'b1000
  } host_mode_e;

  // ------------------------------------------------------------
  // spi framing and type codes (first byte, two top bits)
  // ------------------------------------------------------------
  localparam logic [1:0] SPI_CMD_WRITE = 2'b00;
  localparam logic [1:0] SPI_DATA_WRITE = 2'b10;
  localparam logic [1:0] SPI_STATUS_READ = 2'b01;
  localparam logic [1:0] SPI_DATA_READ = 2'b11;
  localparam logic [4:0] SPI_TYPE_BIT = 5'd1;
  localparam logic [4:0] SPI_FIRST_TX = 5'd8;
  localparam logic [4:0] SPI_LAST_BIT = 5'd15;
  localparam logic [4:0] SPI_FRAME_BITS = 5'd16;
  localparam int SPI_MAX_HZ = 50_000_000;

  // ------------------------------------------------------------
  // i2c
  // ------------------------------------------------------------
  localparam logic [3:0] I2C_BYTE_BITS = 4'd8;
  localparam logic [3:0] I2C_LAST_TX = 4'd7;

  typedef enum logic [7:0] {
    I2C_IDLE = 8'b0000_0001,
    I2C_ADDR = 8'b0000_0010,
    I2C_ADDR_ACK = 8'b0000_0100,
    I2C_WR_BYTE = 8'b0000_1000,
    I2C_WR_ACK = 8'b0001_0000,
    I2C_RD_BYTE = 8'b0010_0000,
    I2C_RD_ACK = 8'b0100_0000,
    I2C_RD_NEXT = 8'b1000_0000
  } i2c_state_e;

  // ------------------------------------------------------------
  // register address handling and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] MEM_PORT_ADDR = 8'h04;
  localparam logic [7:0] REG_ADDR_RESET = 8'h00;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic is_data;
    logic is_write;
    logic [7:0] wdata;
  } host_access_s;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] data;
  } read_bytes_s;

  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] value;
  } spi_word_s;

endpackage

// [rtl/pin_sync.sv]
// two-flop synchroniser, one stage pair per bit
// assumes each bit is an independent level; words need their own crossing
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          meta[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta[i] <= d[i];
          q[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule

// [rtl/serial_host_port.sv]
// serial host port: 3-wire spi, 4-wire spi or i2c slave into the core's access stream
// assumes straps are static; read_bytes change only between spi frames
`timescale 1ns/1ns
module serial_host_port (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [2:0] host_select_strap,
  input wire logic [5:0] i2c_id_strap,
  input wire logic serial_clock_pin,
  input wire logic serial_select_n,
  input wire logic serial_data_io_in,
  output logic serial_data_io_out,
  output logic serial_data_io_oe,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  input wire logic i2c_data_pin_in,
  output logic i2c_data_pin_out,
  output logic i2c_data_pin_oe,
  input wire host_port_pkg::read_bytes_s read_bytes,
  output logic access_valid,
  output host_port_pkg::host_access_s access,
  output logic [7:0] reg_addr,
  output logic mem_advance,
  output host_port_pkg::host_mode_e host_mode
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [12:0] sync_q;
  logic spi_toggle;
  logic [2:0] strap_s;
  logic [5:0] i2c_id_value;
  logic sel_n_s;
  logic scl_s;
  logic sda_s;
  logic toggle_s;

  pin_sync #(.WIDTH(13)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .d({host_select_strap, i2c_id_strap, serial_select_n, serial_clock_pin, i2c_data_pin_in, spi_toggle}),
    .q(sync_q)
  );

  assign {strap_s, i2c_id_value, sel_n_s, scl_s, sda_s, toggle_s} = sync_q;

  // ------------------------------------------------------------
  // link selection
  // ------------------------------------------------------------
  host_port_pkg::host_mode_e next_mode;

  always_comb begin
    next_mode = host_port_pkg::MODE_NONE;
    if (strap_s == host_port_pkg::STRAP_SPI3) begin
      next_mode = host_port_pkg::MODE_SPI3;
    end else if (strap_s == host_port_pkg::STRAP_SPI4) begin
      next_mode = host_port_pkg::MODE_SPI4;
    end else if (strap_s[2:1] == host_port_pkg::STRAP_I2C_HI) begin
      next_mode = host_port_pkg::MODE_I2C;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      host_mode <= host_port_pkg::MODE_NONE;
    end else begin
      host_mode <= next_mode;
    end
  end

  mode_pick_a: assert property (@(posedge mclk) disable iff (!resetn)
    (strap_s == host_port_pkg::STRAP_SPI4) |=> (host_mode == host_port_pkg::MODE_SPI4))
    else $error("4-wire strap did not pick 4-wire mode");

  // ------------------------------------------------------------
  // spi link domain, clocked by the master's serial clock
  // ------------------------------------------------------------
  // select high holds the frame logic in reset, so stray clocks do nothing
  logic spi_on;
  logic spi3;
  logic spi4;
  logic link_rst_n;
  logic spi_din;
  logic [4:0] spi_cnt;
  logic [7:0] spi_shift;
  logic [1:0] spi_type;
  logic spi_read;
  logic [7:0] spi_tx_byte;
  logic spi_bit;
  host_port_pkg::spi_word_s spi_word;
  host_port_pkg::read_bytes_s tx_hold;

  assign spi3 = (host_mode == host_port_pkg::MODE_SPI3);
  assign spi4 = (host_mode == host_port_pkg::MODE_SPI4);
  assign spi_on = spi3 | spi4;
  assign link_rst_n = resetn & ~serial_select_n & spi_on;
  assign spi_din = spi4 ? serial_data_in : serial_data_io_in;
  assign spi_read = (spi_type == host_port_pkg::SPI_STATUS_READ) || (spi_type == host_port_pkg::SPI_DATA_READ);
  assign spi_tx_byte = (spi_type == host_port_pkg::SPI_STATUS_READ) ? tx_hold.status : tx_hold.data;

  always_ff @(posedge serial_clock_pin or negedge link_rst_n) begin
    if (!link_rst_n) begin
      spi_cnt <= 5'd0;
      spi_shift <= 8'h00;
      spi_type <= host_port_pkg::SPI_CMD_WRITE;
    end else if (spi_cnt != host_port_pkg::SPI_FRAME_BITS) begin
      spi_cnt <= spi_cnt + 5'd1;
      spi_shift <= {spi_shift[6:0], spi_din};
      if (spi_cnt == host_port_pkg::SPI_TYPE_BIT) begin
        spi_type <= {spi_shift[0], spi_din};
      end
    end
  end

  // hand-off word survives the frame; mclk reads it after the toggle crosses
  always_ff @(posedge serial_clock_pin or negedge resetn) begin
    if (!resetn) begin
      spi_word <= '0;
      spi_toggle <= 1'b0;
    end else if (link_rst_n && spi_cnt == host_port_pkg::SPI_LAST_BIT) begin
      spi_word <= '{kind: spi_type, value: {spi_shift[6:0], spi_din}};
      spi_toggle <= ~spi_toggle;
    end
  end

  assign spi_bit = spi_tx_byte[3'(host_port_pkg::SPI_LAST_BIT - spi_cnt)];

  always_ff @(negedge serial_clock_pin or negedge link_rst_n) begin
    if (!link_rst_n) begin
      serial_data_io_out <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_io_oe <= 1'b0;
      serial_data_out_oe <= 1'b0;
    end else if (spi_read && spi_cnt >= host_port_pkg::SPI_FIRST_TX && spi_cnt <= host_port_pkg::SPI_LAST_BIT) begin
      serial_data_io_out <= spi_bit;
      serial_data_out <= spi_bit;
      serial_data_io_oe <= spi3;
      serial_data_out_oe <= spi4;
    end else begin
      serial_data_io_oe <= 1'b0;
      serial_data_out_oe <= 1'b0;
    end
  end

  spi_type_cap_a: assert property (@(posedge serial_clock_pin) disable iff (!link_rst_n)
    (spi_cnt == host_port_pkg::SPI_TYPE_BIT) |=> (spi_type == {$past(spi_shift[0]), $past(spi_din)}))
    else $error("spi type not taken from first two bits");

  spi_first_tx_a: assert property (@(posedge serial_clock_pin) disable iff (!link_rst_n)
    (spi_cnt == host_port_pkg::SPI_FIRST_TX && spi_read) |->
    (serial_data_io_out == spi_tx_byte[7]) && (serial_data_io_oe || serial_data_out_oe))
    else $error("read byte msb not launched before ninth rising edge");

  spi3_drive_a: assert property (@(negedge serial_clock_pin) disable iff (!link_rst_n)
    serial_data_io_oe |-> (spi_read && spi3 && spi_cnt >= host_port_pkg::SPI_FIRST_TX))
    else $error("shared data line driven outside a read phase");

  spi4_drive_a: assert property (@(negedge serial_clock_pin) disable iff (!link_rst_n)
    serial_data_out_oe |-> (spi4 && !serial_data_io_oe))
    else $error("4-wire output enabled in the wrong mode");

  // ------------------------------------------------------------
  // spi results into the core domain
  // ------------------------------------------------------------
  logic toggle_d;
  logic spi_evt;

  assign spi_evt = toggle_s ^ toggle_d;

  // read bytes are frozen while a frame runs so the link sees a stable word
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      toggle_d <= 1'b0;
      tx_hold <= '0;
    end else begin
      toggle_d <= toggle_s;
      if (sel_n_s) begin
        tx_hold <= read_bytes;
      end
    end
  end

  spi_release_a: assert property (@(posedge mclk) disable iff (!resetn)
    sel_n_s |-> (!serial_data_io_oe && !serial_data_out_oe))
    else $error("spi output still driven with select high");

  // ------------------------------------------------------------
  // i2c slave, oversampled on the core clock
  // ------------------------------------------------------------
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  logic i2c_on;
  host_port_pkg::i2c_state_e i2c_state;
  logic [3:0] i2c_cnt;
  logic [7:0] i2c_shift;
  logic [7:0] i2c_tx;
  logic [7:0] i2c_load;
  logic i2c_ctype;
  logic i2c_rw;
  logic i2c_fire;
  logic i2c_fire_write;

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign i2c_start = scl_s & scl_d & sda_d & ~sda_s;
  assign i2c_stop = scl_s & scl_d & ~sda_d & sda_s;
  assign i2c_on = (host_mode == host_port_pkg::MODE_I2C);
  assign i2c_load = i2c_ctype ? read_bytes.data : read_bytes.status;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      i2c_data_pin_out <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      i2c_data_pin_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      i2c_state <= host_port_pkg::I2C_IDLE;
      i2c_cnt <= 4'd0;
      i2c_shift <= 8'h00;
      i2c_tx <= 8'h00;
      i2c_ctype <= 1'b0;
      i2c_rw <= 1'b0;
      i2c_data_pin_oe <= 1'b0;
      i2c_fire <= 1'b0;
      i2c_fire_write <= 1'b0;
    end else begin
      i2c_fire <= 1'b0;
      if (!i2c_on || i2c_stop) begin
        i2c_state <= host_port_pkg::I2C_IDLE;
        i2c_data_pin_oe <= 1'b0;
      end else if (i2c_start) begin
        i2c_state <= host_port_pkg::I2C_ADDR;
        i2c_cnt <= 4'd0;
        i2c_data_pin_oe <= 1'b0;
      end else begin
        unique case (i2c_state)
          host_port_pkg::I2C_IDLE: begin
          end
          host_port_pkg::I2C_ADDR: begin
            if (scl_rise) begin
              i2c_shift <= {i2c_shift[6:0], sda_s};
              i2c_cnt <= i2c_cnt + 4'd1;
            end else if (scl_fall && i2c_cnt == host_port_pkg::I2C_BYTE_BITS) begin
              i2c_cnt <= 4'd0;
              if (i2c_shift[7:2] == i2c_id_value) begin
                i2c_state <= host_port_pkg::I2C_ADDR_ACK;
                i2c_data_pin_oe <= 1'b1;
                i2c_ctype <= i2c_shift[1];
                i2c_rw <= i2c_shift[0];
              end else begin
                i2c_state <= host_port_pkg::I2C_IDLE;
              end
            end
          end
          host_port_pkg::I2C_ADDR_ACK, host_port_pkg::I2C_RD_NEXT: begin
            if (scl_fall) begin
              i2c_cnt <= 4'd0;
              if (i2c_rw) begin
                i2c_tx <= i2c_load;
                i2c_data_pin_oe <= ~i2c_load[7];
                i2c_state <= host_port_pkg::I2C_RD_BYTE;
                i2c_fire <= 1'b1;
                i2c_fire_write <= 1'b0;
              end else begin
                i2c_data_pin_oe <= 1'b0;
                i2c_state <= host_port_pkg::I2C_WR_BYTE;
              end
            end
          end
          host_port_pkg::I2C_WR_BYTE: begin
            if (scl_rise) begin
              i2c_shift <= {i2c_shift[6:0], sda_s};
              i2c_cnt <= i2c_cnt + 4'd1;
            end else if (scl_fall && i2c_cnt == host_port_pkg::I2C_BYTE_BITS) begin
              i2c_cnt <= 4'd0;
              i2c_data_pin_oe <= 1'b1;
              i2c_state <= host_port_pkg::I2C_WR_ACK;
              i2c_fire <= 1'b1;
              i2c_fire_write <= 1'b1;
            end
          end
          host_port_pkg::I2C_WR_ACK: begin
            if (scl_fall) begin
              i2c_data_pin_oe <= 1'b0;
              i2c_state <= host_port_pkg::I2C_WR_BYTE;
            end
          end
          host_port_pkg::I2C_RD_BYTE: begin
            if (scl_fall) begin
              if (i2c_cnt == host_port_pkg::I2C_LAST_TX) begin
                i2c_data_pin_oe <= 1'b0;
                i2c_state <= host_port_pkg::I2C_RD_ACK;
              end else begin
                i2c_tx <= {i2c_tx[6:0], 1'b0};
                i2c_data_pin_oe <= ~i2c_tx[6];
                i2c_cnt <= i2c_cnt + 4'd1;
              end
            end
          end
          host_port_pkg::I2C_RD_ACK: begin
            // a nack ends the read; we stay off the bus until the next start
            if (scl_rise) begin
              i2c_state <= sda_s ? host_port_pkg::I2C_IDLE : host_port_pkg::I2C_RD_NEXT;
            end
          end
        endcase
      end
    end
  end

  i2c_passive_a: assert property (@(posedge mclk) disable iff (!resetn)
    (i2c_state == host_port_pkg::I2C_IDLE) |-> !i2c_data_pin_oe)
    else $error("i2c data line driven while not addressed");

  i2c_id_match_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(i2c_state == host_port_pkg::I2C_ADDR_ACK) |-> (i2c_shift[7:2] == i2c_id_value) && i2c_data_pin_oe)
    else $error("i2c acknowledged a foreign address");

  i2c_cycle_kind_a: assert property (@(posedge mclk) disable iff (!resetn)
    (i2c_fire && !spi_evt) |=> access_valid && (access.is_data == $past(i2c_ctype)) && (access.is_write == $past(i2c_fire_write)))
    else $error("i2c cycle type decoded wrongly");

  // ------------------------------------------------------------
  // access stream and register address
  // ------------------------------------------------------------
  logic next_valid;
  host_port_pkg::host_access_s next_access;

  always_comb begin
    next_valid = 1'b0;
    next_access = '0;
    if (spi_evt) begin
      next_valid = 1'b1;
      next_access.is_data = (spi_word.kind == host_port_pkg::SPI_DATA_WRITE) ||
                            (spi_word.kind == host_port_pkg::SPI_DATA_READ);
      next_access.is_write = (spi_word.kind == host_port_pkg::SPI_CMD_WRITE) ||
                             (spi_word.kind == host_port_pkg::SPI_DATA_WRITE);
      next_access.wdata = spi_word.value;
    end else if (i2c_fire) begin
      next_valid = 1'b1;
      next_access.is_data = i2c_ctype;
      next_access.is_write = i2c_fire_write;
      next_access.wdata = i2c_shift;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      access_valid <= 1'b0;
      access <= '0;
      mem_advance <= 1'b0;
      reg_addr <= host_port_pkg::REG_ADDR_RESET;
    end else begin
      access_valid <= next_valid;
      access <= next_access;
      mem_advance <= next_valid && next_access.is_data && (reg_addr == host_port_pkg::MEM_PORT_ADDR);
      if (next_valid && !next_access.is_data && next_access.is_write) begin
        reg_addr <= next_access.wdata;
      end
    end
  end

  addr_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    (access_valid && access.is_data) |-> (reg_addr == $past(reg_addr)))
    else $error("data access moved the register address");

  mem_step_a: assert property (@(posedge mclk) disable iff (!resetn)
    mem_advance |-> (access_valid && access.is_data && reg_addr == host_port_pkg::MEM_PORT_ADDR))
    else $error("memory advance outside a data port access");

endmodule

// [bench/host_master.sv]
// host microcontroller model: spi mode 3 master and i2c master on the serial pins
// assumes the bench resolves the shared data lines and feeds the levels back
`timescale 1ns/1ns
module host_master (
  output logic sclk,
  output logic csn,
  output logic mosi,
  output logic m_oe,
  output logic sda_low,
  input wire logic miso,
  input wire logic sda
);
  // half period 10 ns: 50MHz is the ceiling for the serial clock
  localparam int H = 10;
  localparam int Q = 500;
  initial begin
    sclk = 1'b1; // mode 3 idle level
    csn = 1'b1;
    mosi = 1'b0;
    m_oe = 1'b0;
    sda_low = 1'b0;
  end
  // nbits below 16 gives a truncated frame
  task automatic spi(input logic [1:0] code, input logic [7:0] wb, input int nbits, output logic [7:0] rb);
    logic [15:0] w;
    w = {code, 6'h15, wb}; // type in top bits, payload second
    rb = 8'h00;
    csn = 1'b0; // select low ahead of the first edge
    m_oe = 1'b1;
    #H;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b0;
      mosi = w[15-i];
      if (i == 8 && code[0]) m_oe = 1'b0; // hand the line over for the read byte
      #H;
      sclk = 1'b1;
      if (i >= 8) rb[15-i] = miso;
      #H;
    end
    csn = 1'b1; // held until the last bit is done
    m_oe = 1'b0;
    #H;
  endtask
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      mosi = i[0];
      #H;
      sclk = 1'b1;
      #H;
    end
  endtask
  task automatic i2c_bit(input logic b, output logic r);
    sda_low = !b;
    #Q;
    sclk = 1'b1;
    #Q;
    r = sda;
    #Q;
    sclk = 1'b0;
    #Q;
  endtask
  // msb first; mack 1 releases the ninth bit
  task automatic i2c_xfer(input logic [7:0] b, input logic mack, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], r[i]);
    i2c_bit(mack, ack);
  endtask
  task automatic i2c_start();
    sda_low = 1'b1;
    #Q;
    sclk = 1'b0;
    #Q;
  endtask
  task automatic i2c_stop();
    sda_low = 1'b1;
    #Q;
    sclk = 1'b1;
    #Q;
    sda_low = 1'b0;
    #Q;
  endtask
endmodule

// [bench/serial_host_port_tb.sv]
// self-checking bench of the serial host port: straps, both spi links, i2c link
// assumes host_master stands for the microcontroller on the serial pins
`timescale 1ns/1ns
module serial_host_port_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] strap = 3'b100;
  logic [5:0] id = 6'h00;
  logic four = 1'b0;
  host_port_pkg::read_bytes_s rd_bytes = '0;
  wire logic sclk, csn, mosi, m_oe, sda_low;
  logic io_out, io_oe, so, so_oe, sda_out, sda_oe, valid, adv;
  logic [7:0] reg_addr;
  host_port_pkg::host_access_s acc, last;
  host_port_pkg::host_mode_e mode;
  int fail_count = 0;
  int checks = 0;
  int acc_n = 0;
  int adv_n = 0;
  int cyc = 0;
  // a released line toggles so a stale level never passes for data
  wire logic io_line = io_oe ? io_out : (m_oe ? mosi : mclk);
  wire logic miso = four ? (so_oe ? so : mclk) : io_line;
  wire logic sda = !((sda_oe && !sda_out) || sda_low);
  serial_host_port u_serial_host_port (.mclk(mclk), .resetn(resetn), .host_select_strap(strap),
    .i2c_id_strap(id), .serial_clock_pin(sclk), .serial_select_n(csn), .serial_data_io_in(io_line),
    .serial_data_io_out(io_out), .serial_data_io_oe(io_oe), .serial_data_in(mosi), .serial_data_out(so),
    .serial_data_out_oe(so_oe), .i2c_data_pin_in(sda), .i2c_data_pin_out(sda_out), .i2c_data_pin_oe(sda_oe),
    .read_bytes(rd_bytes), .access_valid(valid), .access(acc), .reg_addr(reg_addr), .mem_advance(adv),
    .host_mode(mode));
  host_master u_host_master (.sclk(sclk), .csn(csn), .mosi(mosi), .m_oe(m_oe), .sda_low(sda_low),
    .miso(miso), .sda(sda));
  always #25 mclk = ~mclk;
  // ------------------------------------------------------------
  // access monitor and hang guard
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (valid === 1'b1) begin
      acc_n++;
      last = acc;
      adv_n += int'(adv === 1'b1);
    end
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic host_port_pkg::host_mode_e exp_mode(input logic [2:0] s);
    if (s[2:1] == 2'b11) return host_port_pkg::MODE_I2C;
    if (s == 3'b101) return host_port_pkg::MODE_SPI4;
    if (s == 3'b100) return host_port_pkg::MODE_SPI3;
    return host_port_pkg::MODE_NONE;
  endfunction
  task automatic restart(input logic [2:0] s);
    @(posedge mclk);
    #2;
    resetn = 1'b0;
    strap = s;
    four = (s == 3'b101);
    id = 6'($urandom);
    repeat (3) @(posedge mclk);
    chk(mode === host_port_pkg::MODE_NONE && reg_addr === 8'h00 && valid === 1'b0, "reset values");
    #2;
    resetn = 1'b1;
    repeat (5) @(posedge mclk);
    #2;
    chk(mode === exp_mode(s), "mode from strap");
  endtask
  // fresh read bytes well before select falls, as they are sampled quasi-static
  task automatic new_bytes();
    @(posedge mclk);
    #2;
    rd_bytes = 16'($urandom);
    repeat (3) @(posedge mclk);
  endtask
  task automatic spi_op(input logic [1:0] code, input logic [7:0] v);
    logic [7:0] rb, a0;
    int n0;
    new_bytes();
    n0 = acc_n;
    a0 = reg_addr;
    u_host_master.spi(code, v, 16, rb);
    repeat (8) @(posedge mclk);
    #2;
    chk(acc_n == n0 + 1 && last.is_data === code[1] && last.is_write === !code[0], "spi kind");
    if (!code[0]) chk(last.wdata === v, "spi write byte");
    chk(reg_addr === (code == 2'b00 ? v : a0), "register address");
    if (code[0]) chk(rb === (code[1] ? rd_bytes.data : rd_bytes.status), "spi read byte");
    chk(io_oe === 1'b0 && so_oe === 1'b0, "outputs released");
  endtask
  task automatic i2c_op(input logic a0, input logic rd, input logic [5:0] dev, input logic [7:0] v, input int nb);
    logic [7:0] r;
    logic ack, hit;
    int n0;
    new_bytes();
    hit = (dev == id);
    n0 = acc_n;
    u_host_master.i2c_start();
    u_host_master.i2c_xfer({dev, a0, rd}, 1'b1, r, ack);
    chk(ack === !hit, "address acknowledge");
    // a master ack on all but the last read byte walks the multi-byte read path
    for (int b = 0; b < nb; b++) if (hit) u_host_master.i2c_xfer(rd ? 8'hff : v, !rd || b == nb - 1, r, ack);
    if (hit && !rd) chk(ack === 1'b0, "write byte acknowledge");
    u_host_master.i2c_stop();
    repeat (4) @(posedge mclk);
    #2;
    chk(acc_n == n0 + (hit ? nb : 0), "one access per byte");
    if (hit) chk(last.is_data === a0 && last.is_write === !rd, "i2c cycle type");
    if (hit && !rd) chk(last.wdata === v, "i2c write byte");
    if (hit && rd) chk(r === (a0 ? rd_bytes.data : rd_bytes.status), "i2c read byte");
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] rb;
    int n;
    void'($urandom(67));
    for (int s = 0; s < 8; s++) restart(3'(s));
    for (int f = 0; f < 2; f++) begin
      restart(f == 1 ? 3'b101 : 3'b100);
      for (int k = 0; k < 4; k++) spi_op(2'(k), 8'($urandom));
      spi_op(2'b00, 8'h04);
      n = adv_n;
      spi_op(2'b10, 8'($urandom));
      spi_op(2'b11, 8'hff);
      chk(adv_n == n + 2, "data port advances");
      spi_op(2'b00, 8'h05);
      spi_op(2'b10, 8'h00);
      chk(adv_n == n + 2, "no advance elsewhere");
      n = acc_n;
      u_host_master.idle_clocks(16);
      u_host_master.spi(2'b10, 8'h3c, 9, rb);
      repeat (8) @(posedge mclk);
      chk(acc_n == n, "stray clocks and short frame");
      spi_op(2'b01, 8'h00); // clean frame right after the short one
    end
    restart(3'b110);
    for (int k = 0; k < 4; k++) i2c_op(k[1], k[0], id, 8'($urandom), 2);
    i2c_op(1'b0, 1'b0, id, 8'h04, 1);
    chk(reg_addr === 8'h04, "i2c command sets address");
    i2c_op(1'b1, 1'b0, id ^ 6'h20, 8'h5a, 1);
    restart(3'b111);
    i2c_op(1'b1, 1'b1, id, 8'h00, 1);
    results();
  end
endmodule
